// ### rcu_map.svh
// register map, field positions, reset values and timing of the reset unit
`ifndef RCU_MAP_SVH
`define RCU_MAP_SVH

`define RCU_ADDR_W        8
`define RCU_CTRL_OFS      8'h00
`define RCU_STAT_OFS      8'h04
`define RCU_MODE_OFS      8'h08
`define RCU_IMR_OFS       8'h0C

`define RCU_CTRL_PROC_BIT 0
`define RCU_CTRL_PERI_BIT 2
`define RCU_CTRL_EXT_BIT  3

`define RCU_EV_LSB        0
`define RCU_EV_W          2
`define RCU_EV_USER       0
`define RCU_EV_SWDONE     1
`define RCU_CAUSE_LSB     8
`define RCU_CAUSE_W       3
`define RCU_PIN_BIT       16
`define RCU_BUSY_BIT      17

`define RCU_MODE_UEN_BIT  0
`define RCU_MODE_LEN_LSB  8
`define RCU_LEN_W         4

`define RCU_UEN_RST       1'h1
`define RCU_LEN_RST       4'h0
`define RCU_IMR_RST       2'h0
`define RCU_CAUSE_RST     3'h0
`define RCU_CAUSE_SW      3'h3
`define RCU_CAUSE_USER    3'h4

`define RCU_SYS_CLK_HZ    50000000
`define RCU_SLOW_CLK_HZ   32768
`define RCU_TRIG_DLY      2
`define RCU_STARTUP_CYC   3
`define RCU_CNT_W         17

`define RCU_RESP_OKAY     2'h0
`define RCU_RESP_DECERR   2'h3

`endif

// ### rcu_pkg.sv
// types shared by the reset unit
package rcu_pkg;
`include "rcu_map.svh"

    typedef enum logic [4:0] {
        ST_IDLE    = 5'h01,
        ST_UTRIG   = 5'h02,
        ST_UHOLD   = 5'h04,
        ST_STARTUP = 5'h08,
        ST_SWRST   = 5'h10
    } rcu_state_e;

    typedef struct packed {
        logic [`RCU_ADDR_W-1:0] addr;
        logic [31:0]            data;
        logic [3:0]             strb;
    } rcu_wreq_s;

    function automatic logic rcu_addr_ok(
        input logic [`RCU_ADDR_W-1:0] a
    );
        case (a)
            `RCU_CTRL_OFS, `RCU_STAT_OFS,
            `RCU_MODE_OFS, `RCU_IMR_OFS: rcu_addr_ok = 1'b1;
            default:                     rcu_addr_ok = 1'b0;
        endcase
    endfunction : rcu_addr_ok

endpackage : rcu_pkg

// ### rcu_sync2.sv
// two-flop synchroniser for one level
`timescale 1ns/1ns
module rcu_sync2
    import rcu_pkg::*;
#(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic i_sys_clk,
    input  wire logic i_rst_n,
    input  wire logic i_d,
    output logic      o_q
);
    logic meta;
    logic next_meta;
    logic next_q;

    always_comb begin
        next_meta = i_d;
        next_q    = meta;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= RST_VAL;
            o_q  <= RST_VAL;
        end else begin
            meta <= next_meta;
            o_q  <= next_q;
        end
    end
endmodule : rcu_sync2

// ### rcu_axil.sv
// axi4-lite slave front end of the reset unit
`timescale 1ns/1ns
`include "rcu_map.svh"
module rcu_axil
    import rcu_pkg::*;
(
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_rst_n,
    input  wire logic [`RCU_ADDR_W-1:0] i_awaddr,
    input  wire logic                   i_awvalid,
    output logic                        o_awready,
    input  wire logic [31:0]            i_wdata,
    input  wire logic [3:0]             i_wstrb,
    input  wire logic                   i_wvalid,
    output logic                        o_wready,
    output logic [1:0]                  o_bresp,
    output logic                        o_bvalid,
    input  wire logic                   i_bready,
    input  wire logic [`RCU_ADDR_W-1:0] i_araddr,
    input  wire logic                   i_arvalid,
    output logic                        o_arready,
    output logic [31:0]                 o_rdata,
    output logic [1:0]                  o_rresp,
    output logic                        o_rvalid,
    input  wire logic                   i_rready,
    output rcu_wreq_s                   o_wreq,
    output logic                        o_wr_en,
    output logic                        o_rd_en,
    output logic [`RCU_ADDR_W-1:0]      o_rd_addr,
    input  wire logic [31:0]            i_rd_data
);
    logic                   aw_full, w_full;
    logic                   next_aw_full, next_w_full;
    logic                   next_awready, next_wready, next_arready;
    logic                   next_bvalid, next_rvalid;
    logic [1:0]             next_bresp, next_rresp;
    logic [31:0]            next_rdata;
    rcu_wreq_s              next_wreq;
    logic                   next_wr_en, next_rd_en;
    logic [`RCU_ADDR_W-1:0] next_rd_addr;

    always_comb begin
        next_aw_full = aw_full;
        next_w_full  = w_full;
        next_awready = o_awready;
        next_wready  = o_wready;
        next_arready = o_arready;
        next_bvalid  = o_bvalid;
        next_bresp   = o_bresp;
        next_rvalid  = o_rvalid;
        next_rresp   = o_rresp;
        next_rdata   = o_rdata;
        next_wreq    = o_wreq;
        next_rd_addr = o_rd_addr;
        next_wr_en   = 1'b0;
        next_rd_en   = 1'b0;
        // address and data taken in either order
        if (i_awvalid && o_awready) begin
            next_wreq.addr = i_awaddr;
            next_aw_full   = 1'b1;
            next_awready   = 1'b0;
        end
        if (i_wvalid && o_wready) begin
            next_wreq.data = i_wdata;
            next_wreq.strb = i_wstrb;
            next_w_full    = 1'b1;
            next_wready    = 1'b0;
        end
        if (aw_full && w_full) begin
            next_wr_en   = 1'b1;
            next_bvalid  = 1'b1;
            next_bresp   = rcu_addr_ok(o_wreq.addr) ? `RCU_RESP_OKAY
                                                    : `RCU_RESP_DECERR;
            next_aw_full = 1'b0;
            next_w_full  = 1'b0;
        end
        if (o_bvalid && i_bready) begin
            next_bvalid  = 1'b0;
            next_awready = 1'b1;
            next_wready  = 1'b1;
        end
        // read: address taken, data captured one cycle later
        if (i_arvalid && o_arready) begin
            next_arready = 1'b0;
            next_rd_en   = 1'b1;
            next_rd_addr = i_araddr;
        end
        if (o_rd_en) begin
            next_rvalid = 1'b1;
            if (rcu_addr_ok(o_rd_addr)) begin
                next_rdata = i_rd_data;
                next_rresp = `RCU_RESP_OKAY;
            end else begin
                next_rdata = 32'h0000_0000;
                next_rresp = `RCU_RESP_DECERR;
            end
        end
        if (o_rvalid && i_rready) begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_full   <= 1'b0;
            w_full    <= 1'b0;
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
            o_arready <= 1'b1;
            o_bvalid  <= 1'b0;
            o_bresp   <= `RCU_RESP_OKAY;
            o_rvalid  <= 1'b0;
            o_rresp   <= `RCU_RESP_OKAY;
            o_rdata   <= 32'h0000_0000;
            o_wreq    <= '0;
            o_wr_en   <= 1'b0;
            o_rd_en   <= 1'b0;
            o_rd_addr <= '0;
        end else begin
            aw_full   <= next_aw_full;
            w_full    <= next_w_full;
            o_awready <= next_awready;
            o_wready  <= next_wready;
            o_arready <= next_arready;
            o_bvalid  <= next_bvalid;
            o_bresp   <= next_bresp;
            o_rvalid  <= next_rvalid;
            o_rresp   <= next_rresp;
            o_rdata   <= next_rdata;
            o_wreq    <= next_wreq;
            o_wr_en   <= next_wr_en;
            o_rd_en   <= next_rd_en;
            o_rd_addr <= next_rd_addr;
        end
    end
endmodule : rcu_axil

// ### rcu_top.sv
// reset unit: software reset, user reset and reset pin manager
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "rcu_map.svh"
module rcu_top
    import rcu_pkg::*;
#(
    parameter int SLOW_DIV = `RCU_SYS_CLK_HZ / `RCU_SLOW_CLK_HZ
) (
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_rst_n,
    input  wire logic [`RCU_ADDR_W-1:0] i_s_axi_awaddr,
    input  wire logic                   i_s_axi_awvalid,
    output logic                        o_s_axi_awready,
    input  wire logic [31:0]            i_s_axi_wdata,
    input  wire logic [3:0]             i_s_axi_wstrb,
    input  wire logic                   i_s_axi_wvalid,
    output logic                        o_s_axi_wready,
    output logic [1:0]                  o_s_axi_bresp,
    output logic                        o_s_axi_bvalid,
    input  wire logic                   i_s_axi_bready,
    input  wire logic [`RCU_ADDR_W-1:0] i_s_axi_araddr,
    input  wire logic                   i_s_axi_arvalid,
    output logic                        o_s_axi_arready,
    output logic [31:0]                 o_s_axi_rdata,
    output logic [1:0]                  o_s_axi_rresp,
    output logic                        o_s_axi_rvalid,
    input  wire logic                   i_s_axi_rready,
    input  wire logic                   i_reset_pin_n,
    output logic                        o_reset_pin_n,
    output logic                        o_reset_pin_oe,
    output logic                        o_proc_rst_n,
    output logic                        o_periph_rst_n,
    output logic                        o_proc_clk_en,
    output logic                        o_irq
);
    localparam int CNT_W = `RCU_CNT_W;
    localparam int DIV_W = $clog2(SLOW_DIV + 1);
    localparam logic [CNT_W-1:0] TRIG_CNT  = CNT_W'(`RCU_TRIG_DLY);
    localparam logic [CNT_W-1:0] START_CNT = CNT_W'(`RCU_STARTUP_CYC);
    localparam logic [CNT_W-1:0] ONE       = CNT_W'(1);

    function automatic logic [CNT_W-1:0] len_cycles(
        input logic [`RCU_LEN_W-1:0] l
    );
        len_cycles = ONE << ({1'b0, l} + 5'h01);
    endfunction : len_cycles

    rcu_wreq_s              wreq;
    logic                   wr_en, rd_en;
    logic [`RCU_ADDR_W-1:0] rd_addr;
    logic [31:0]            rd_data;
    logic                   pin_sync;

    // slow clock tick
    logic [DIV_W-1:0] div_cnt, next_div_cnt;
    logic             tick, next_tick;

    // configuration
    logic                  uen, next_uen;
    logic [`RCU_LEN_W-1:0] len, next_len;
    logic [`RCU_EV_W-1:0]  imr, next_imr;

    // sequencer
    rcu_state_e               state, next_state;
    logic [CNT_W-1:0]         cnt, next_cnt;
    logic [CNT_W-1:0]         drv_cnt, next_drv_cnt;
    logic [1:0]               pin_smp, next_pin_smp;
    logic                     proc_rst_n, next_proc_rst_n;
    logic                     peri_rst_n, next_peri_rst_n;
    logic                     clk_en, next_clk_en;
    logic                     drv_oe, next_drv_oe;
    logic                     pin_lvl, next_pin_lvl;
    logic                     guard, next_guard;
    logic                     busy, next_busy;
    logic                     sw_proc, next_sw_proc;
    logic                     sw_ext, next_sw_ext;
    logic [`RCU_CAUSE_W-1:0]  cause, next_cause;
    logic [`RCU_EV_W-1:0]     ev, next_ev;
    logic [`RCU_EV_W-1:0]     ev_set, ev_clr;
    logic                     irq, next_irq;

    logic pin_high;
    logic wr_ctrl, wr_mode, wr_imr;
    logic cmd_proc, cmd_peri, cmd_ext;

    rcu_axil u_axil (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_awaddr  (i_s_axi_awaddr),
        .i_awvalid (i_s_axi_awvalid),
        .o_awready (o_s_axi_awready),
        .i_wdata   (i_s_axi_wdata),
        .i_wstrb   (i_s_axi_wstrb),
        .i_wvalid  (i_s_axi_wvalid),
        .o_wready  (o_s_axi_wready),
        .o_bresp   (o_s_axi_bresp),
        .o_bvalid  (o_s_axi_bvalid),
        .i_bready  (i_s_axi_bready),
        .i_araddr  (i_s_axi_araddr),
        .i_arvalid (i_s_axi_arvalid),
        .o_arready (o_s_axi_arready),
        .o_rdata   (o_s_axi_rdata),
        .o_rresp   (o_s_axi_rresp),
        .o_rvalid  (o_s_axi_rvalid),
        .i_rready  (i_s_axi_rready),
        .o_wreq    (wreq),
        .o_wr_en   (wr_en),
        .o_rd_en   (rd_en),
        .o_rd_addr (rd_addr),
        .i_rd_data (rd_data)
    );

    rcu_sync2 #(
        .RST_VAL (1'b1)
    ) u_pin_sync (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_d       (i_reset_pin_n),
        .o_q       (pin_sync)
    );

    assign pin_high = &pin_smp;
    assign wr_ctrl  = wr_en && (wreq.addr == `RCU_CTRL_OFS) && wreq.strb[0];
    assign wr_mode  = wr_en && (wreq.addr == `RCU_MODE_OFS);
    assign wr_imr   = wr_en && (wreq.addr == `RCU_IMR_OFS) && wreq.strb[0];
    assign cmd_proc = wreq.data[`RCU_CTRL_PROC_BIT];
    assign cmd_peri = wreq.data[`RCU_CTRL_PERI_BIT];
    assign cmd_ext  = wreq.data[`RCU_CTRL_EXT_BIT];
    assign ev_clr   = (rd_en && (rd_addr == `RCU_STAT_OFS)) ? '1 : '0;

    // slow clock tick divider
    always_comb begin
        next_tick    = 1'b0;
        next_div_cnt = div_cnt + DIV_W'(1);
        if (div_cnt == DIV_W'(SLOW_DIV - 1)) begin
            next_div_cnt = '0;
            next_tick    = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_cnt <= '0;
            tick    <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            tick    <= next_tick;
        end
    end

    // mode and mask registers
    always_comb begin
        next_uen = uen;
        next_len = len;
        next_imr = imr;
        if (wr_mode && wreq.strb[0]) begin
            next_uen = wreq.data[`RCU_MODE_UEN_BIT];
        end
        if (wr_mode && wreq.strb[1]) begin
            next_len = wreq.data[`RCU_MODE_LEN_LSB +: `RCU_LEN_W];
        end
        if (wr_imr) begin
            next_imr = wreq.data[`RCU_EV_LSB +: `RCU_EV_W];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            uen <= `RCU_UEN_RST;
            len <= `RCU_LEN_RST;
            imr <= `RCU_IMR_RST;
        end else begin
            uen <= next_uen;
            len <= next_len;
            imr <= next_imr;
        end
    end

    // reset sequencer
    always_comb begin
        next_state      = state;
        next_cnt        = cnt;
        next_drv_cnt    = drv_cnt;
        next_pin_smp    = pin_smp;
        next_proc_rst_n = proc_rst_n;
        next_peri_rst_n = peri_rst_n;
        next_clk_en     = clk_en;
        next_drv_oe     = drv_oe;
        next_pin_lvl    = 1'b0;
        next_guard      = guard;
        next_busy       = busy;
        next_sw_proc    = sw_proc;
        next_sw_ext     = sw_ext;
        next_cause      = cause;
        ev_set          = '0;
        if (tick) begin
            next_pin_smp = {pin_smp[0], pin_sync};
        end
        if (tick && drv_oe) begin
            next_drv_cnt = drv_cnt - ONE;
            if (drv_cnt <= ONE) begin
                next_drv_oe = 1'b0;
            end
        end
        if (tick && !drv_oe && pin_high) begin
            next_guard = 1'b0;
        end
        case (state)
            ST_IDLE: begin
                if (wr_ctrl && !busy
                        && (cmd_proc || cmd_peri || cmd_ext)) begin
                    next_state   = ST_SWRST;
                    next_busy    = 1'b1;
                    next_cnt     = START_CNT;
                    next_sw_proc = cmd_proc;
                    next_sw_ext  = cmd_ext;
                    if (cmd_proc) begin
                        next_proc_rst_n = 1'b0;
                    end
                    if (cmd_peri) begin
                        next_peri_rst_n = 1'b0;
                    end
                    if (cmd_ext) begin
                        next_drv_oe  = 1'b1;
                        next_drv_cnt = len_cycles(len);
                        next_guard   = 1'b1;
                    end
                end else if (tick && !pin_sync && uen
                             && !guard && !drv_oe) begin
                    next_state = ST_UTRIG;
                    next_cnt   = TRIG_CNT;
                end
            end
            ST_UTRIG: begin
                if (tick) begin
                    next_cnt = cnt - ONE;
                    if (cnt <= ONE) begin
                        next_proc_rst_n = 1'b0;
                        next_peri_rst_n = 1'b0;
                        next_clk_en     = 1'b0;
                        next_state      = ST_UHOLD;
                    end
                end
            end
            ST_UHOLD: begin
                if (tick && pin_high) begin
                    next_clk_en = 1'b1;
                    next_cnt    = START_CNT;
                    next_state  = ST_STARTUP;
                end
            end
            ST_STARTUP: begin
                if (tick) begin
                    next_cnt = cnt - ONE;
                    if (cnt <= ONE) begin
                        next_proc_rst_n = 1'b1;
                        next_peri_rst_n = 1'b1;
                        next_cause      = `RCU_CAUSE_USER;
                        ev_set[`RCU_EV_USER] = 1'b1;
                        next_state      = ST_IDLE;
                    end
                end
            end
            ST_SWRST: begin
                if (tick) begin
                    if (cnt > ONE) begin
                        next_cnt = cnt - ONE;
                    end else if (!drv_oe && (pin_high || !sw_ext)) begin
                        next_proc_rst_n = 1'b1;
                        next_peri_rst_n = 1'b1;
                        next_busy       = 1'b0;
                        ev_set[`RCU_EV_SWDONE] = 1'b1;
                        if (sw_proc) begin
                            next_cause = `RCU_CAUSE_SW;
                        end
                        next_state = ST_IDLE;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        next_ev  = (ev & ~ev_clr) | ev_set;
        next_irq = |(next_ev & next_imr);
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state      <= ST_IDLE;
            cnt        <= '0;
            drv_cnt    <= '0;
            pin_smp    <= 2'h3;
            proc_rst_n <= 1'b1;
            peri_rst_n <= 1'b1;
            clk_en     <= 1'b1;
            drv_oe     <= 1'b0;
            pin_lvl    <= 1'b0;
            guard      <= 1'b0;
            busy       <= 1'b0;
            sw_proc    <= 1'b0;
            sw_ext     <= 1'b0;
            cause      <= `RCU_CAUSE_RST;
            ev         <= '0;
            irq        <= 1'b0;
        end else begin
            state      <= next_state;
            cnt        <= next_cnt;
            drv_cnt    <= next_drv_cnt;
            pin_smp    <= next_pin_smp;
            proc_rst_n <= next_proc_rst_n;
            peri_rst_n <= next_peri_rst_n;
            clk_en     <= next_clk_en;
            drv_oe     <= next_drv_oe;
            pin_lvl    <= next_pin_lvl;
            guard      <= next_guard;
            busy       <= next_busy;
            sw_proc    <= next_sw_proc;
            sw_ext     <= next_sw_ext;
            cause      <= next_cause;
            ev         <= next_ev;
            irq        <= next_irq;
        end
    end

    // register read mux
    always_comb begin
        rd_data = 32'h0000_0000;
        case (rd_addr)
            `RCU_STAT_OFS: begin
                rd_data[`RCU_EV_LSB +: `RCU_EV_W]       = ev;
                rd_data[`RCU_CAUSE_LSB +: `RCU_CAUSE_W] = cause;
                rd_data[`RCU_PIN_BIT]                   = pin_high;
                rd_data[`RCU_BUSY_BIT]                  = busy;
            end
            `RCU_MODE_OFS: begin
                rd_data[`RCU_MODE_UEN_BIT]                 = uen;
                rd_data[`RCU_MODE_LEN_LSB +: `RCU_LEN_W] = len;
            end
            `RCU_IMR_OFS: begin
                rd_data[`RCU_EV_LSB +: `RCU_EV_W] = imr;
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    assign o_reset_pin_n  = pin_lvl;
    assign o_reset_pin_oe = drv_oe;
    assign o_proc_rst_n   = proc_rst_n;
    assign o_periph_rst_n = peri_rst_n;
    assign o_proc_clk_en  = clk_en;
    assign o_irq          = irq;
endmodule : rcu_top

// ### rcu_sva.sv
// assertion checker for the reset unit ports
`timescale 1ns/1ns
module rcu_sva #(
    parameter int SLOW_DIV = 4
) (
    input wire logic       i_sys_clk,
    input wire logic       i_rst_n,
    input wire logic       i_s_axi_awvalid,
    input wire logic       o_s_axi_awready,
    input wire logic       i_s_axi_wvalid,
    input wire logic       o_s_axi_wready,
    input wire logic       o_s_axi_bvalid,
    input wire logic       i_s_axi_arvalid,
    input wire logic       o_s_axi_arready,
    input wire logic       o_s_axi_rvalid,
    input wire logic       i_s_axi_rready,
    input wire logic       i_reset_pin_n,
    input wire logic       o_reset_pin_n,
    input wire logic       o_reset_pin_oe,
    input wire logic       o_proc_rst_n,
    input wire logic       o_periph_rst_n,
    input wire logic       o_proc_clk_en
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_wr_take;
        i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
    endsequence
    sequence s_startup;
        !o_proc_rst_n [*8] ##[1:8] $rose(o_proc_rst_n);
    endsequence
    a_pin_low_out: assert property (o_reset_pin_oe |->
        !o_reset_pin_n) else $error("pin driven high");
    a_wr_answer: assert property (s_wr_take |=> !o_s_axi_awready
        ##1 o_s_axi_bvalid) else $error("write answer late");
    a_rd_answer: assert property (i_s_axi_arvalid && o_s_axi_arready
        |-> ##2 o_s_axi_rvalid) else $error("read answer late");
    a_rd_done: assert property (o_s_axi_rvalid && i_s_axi_rready
        |=> !o_s_axi_rvalid ##[0:1] o_s_axi_arready) else $error("rd done");
    a_start_pair: assert property ($fell(o_proc_clk_en) |->
        !o_proc_rst_n && !o_periph_rst_n) else $error("user reset split");
    a_pin_hold: assert property (!i_reset_pin_n && !o_proc_clk_en |->
        !o_proc_rst_n && !o_periph_rst_n) else $error("reset left early");
    a_startup_end: assert property ($rose(o_proc_clk_en) |-> s_startup)
        else $error("startup length wrong");
    a_no_self: assert property ($fell(o_reset_pin_oe) |->
        o_proc_clk_en [*8]) else $error("own drive made user reset");
endmodule : rcu_sva
bind rcu_top rcu_sva #(.SLOW_DIV(SLOW_DIV)) rcu_sva_inst (.*);

// ### rcu_pin_ext.sv
// outside circuitry on the reset pin: pull-up and a holder
`timescale 1ns/1ns
module rcu_pin_ext (
    input  wire logic i_dev_oe,
    input  wire logic i_dev_out,
    input  wire logic i_hold_low,
    output logic      o_pin_n
);
    assign o_pin_n = !((i_dev_oe && !i_dev_out) || i_hold_low);
endmodule : rcu_pin_ext

// ### testbench.sv
// self-checking bench for the reset unit
`timescale 1ns/1ns
module testbench;
    import rcu_pkg::*;
    logic        clk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0;
    logic        rr = 0, hold = 0, awr, wr, bv, arr, rv, pin_n, pout_n;
    logic        poe, prst_n, perst_n, cen, irq;
    logic [7:0]  aa = 0, ra = 0;
    logic [31:0] wd = 0, rd, rdat;
    logic [1:0]  rresp, bresp;
    int          err_count = 0, cmp_count = 0, len, n, c, ev = 0, cause = 0;
    always #10 clk = ~clk;
    rcu_top #(.SLOW_DIV(4)) rcu_top_inst (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_s_axi_awaddr(aa),
        .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd),
        .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr),
        .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv), .i_s_axi_bready(br),
        .i_s_axi_araddr(ra), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
        .o_s_axi_rdata(rdat), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rv),
        .i_s_axi_rready(rr), .i_reset_pin_n(pin_n), .o_reset_pin_n(pout_n),
        .o_reset_pin_oe(poe), .o_proc_rst_n(prst_n),
        .o_periph_rst_n(perst_n), .o_proc_clk_en(cen), .o_irq(irq));
    rcu_pin_ext rcu_pin_ext_inst (.i_dev_oe(poe), .i_dev_out(pout_n),
        .i_hold_low(hold), .o_pin_n(pin_n));
    task automatic report_and_stop;
        $display("compares %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic tmo(input logic ok);
        if (!ok) begin
            err_count++;
            report_and_stop();
        end
    endtask : tmo
    task automatic wt(ref logic s, input logic v);
        n = 0;
        while (s !== v && n < 400) begin
            @(posedge clk);
            n++;
        end
        tmo(s === v);
    endtask : wt
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        aa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        for (n = 0; n < 400 && !(bv && br); n++) begin
            @(posedge clk);
            if (awv && awr)
                awv <= 1'b0;
            if (wv && wr)
                wv <= 1'b0;
        end
        tmo(bv && br);
        br <= 1'b0;
        @(posedge clk);
    endtask : axw
    task automatic axr(input logic [7:0] a);
        ra <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        for (n = 0; n < 400 && !(rv && rr); n++) begin
            @(posedge clk);
            if (arv && arr)
                arv <= 1'b0;
        end
        tmo(rv && rr);
        rd = rdat;
        rr <= 1'b0;
        @(posedge clk);
    endtask : axr
    task automatic st(input int b);
        axr(8'h04);
        chk(rd, 32'(ev | cause << 8 | b << 16));
        ev = 0;
    endtask : st
    initial begin
        void'($urandom(32'hB8DFDB77));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        axr(8'h08);
        chk(rd, 32'h1);
        axr(8'h10);
        chk(rresp, 2'h3);
        axw(8'h10, 32'h0);
        chk(bresp, 2'h3);
        axw(8'h0C, 32'h3);
        chk(bresp, 2'h0);
        st(1);
        hold <= 1'b1;
        wt(cen, 1'b0);
        chk({prst_n, perst_n}, 2'h0);
        repeat (8) @(posedge clk);
        hold <= 1'b0;
        wt(prst_n, 1'b1);
        ev = 1;
        cause = 4;
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        st(1);
        chk(irq, 1'b0);
        len = $urandom % 3;
        axw(8'h08, 32'(len << 8));
        hold <= 1'b1;
        repeat (40) @(posedge clk);
        chk({cen, prst_n}, 2'h3);
        hold <= 1'b0;
        repeat (16) @(posedge clk);
        axw(8'h08, 32'(len << 8 | 1));
        axr(8'h08);
        chk(rd, 32'(len << 8 | 1));
        axw(8'h00, 32'hC);
        hold <= 1'b1;
        for (c = 0; poe === 1'b1 && c < 600; c++)
            @(posedge clk);
        tmo(c < 600);
        chk(c >= (8 << len) - 6 && c <= (8 << len) + 4, 1);
        axw(8'h00, 32'h1);
        st(2);
        chk({perst_n, prst_n, cen}, 3'h3);
        hold <= 1'b0;
        wt(perst_n, 1'b1);
        ev = 2;
        st(1);
        axw(8'h00, 32'h1);
        wt(prst_n, 1'b0);
        wt(prst_n, 1'b1);
        ev = 2;
        cause = 3;
        st(1);
        report_and_stop();
    end
endmodule : testbench
